// >>> src/two_wire_master_map.svh
// offsets, field positions, reset values and timing counts
`ifndef TWO_WIRE_MASTER_MAP_SVH
`define TWO_WIRE_MASTER_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_BUS_CONTROL 4'h0
`define OFS_BUS_STATUS 4'h4
`define OFS_SHIFT_DATA 4'h8

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define CTL_FLAG 7
`define CTL_ACK_ENABLE 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_WCOL 3
`define CTL_ENABLE 2
`define CTL_INT_ENABLE 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTL_RESET 8'h00
`define DATA_RESET 8'hff
`define STATUS_RESET 8'hf8

// ----------------------------------------------------------------
// status codes, prescaler bits zero
// ----------------------------------------------------------------
`define ST_START 8'h08
`define ST_RESTART 8'h10
`define ST_ADDR_W_ACK 8'h18
`define ST_ADDR_W_NACK 8'h20
`define ST_DATA_ACK 8'h28
`define ST_DATA_NACK 8'h30
`define ST_ARB_LOST 8'h38
`define ST_ADDR_R_ACK 8'h40
`define ST_ADDR_R_NACK 8'h48
`define ST_IDLE 8'hf8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define BIT_TIME_NS 10000
`define QUARTER_CYCLES (`BIT_TIME_NS / 4 / `CLK_PERIOD_NS)

`endif

// >>> src/two_wire_master_pkg.sv
// types shared by the two-wire master transmitter
package two_wire_master_pkg;

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE    = 7'b0000001,
    S_WAIT    = 7'b0000010,
    S_START   = 7'b0000100,
    S_RESTART = 7'b0001000,
    S_BIT     = 7'b0010000,
    S_HOLD    = 7'b0100000,
    S_STOP    = 7'b1000000
  } engine_state_e;

  // ----------------------------------------------------------------
  // control register contents
  // ----------------------------------------------------------------
  typedef struct packed {
    logic flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision;
    logic enable;
    logic interrupt_enable;
  } bus_control_s;

endpackage : two_wire_master_pkg

// >>> src/two_wire_master_transmitter.sv
// two-wire bus master transmitter with avalon-mm register access
//
// Operation
// [R1] software starts: flag, start, enable set
// [R2] writing one clears flag; zero keeps it
// [R3] start only once bus is free
// [R4] after start: flag set, status 0x08
// [R5] software loads address byte, clears flag
// [R6] address sent: flag set, 0x18/0x20/0x38
// [R7] 0x18/0x20 address, 0x28/0x30 data ack/nack
// [R8] software sends data byte per flag clear
// [R9] data write with flag low: ignored, collision
// [R10] load and clear in ack states sends byte
// [R11] stop request: send stop, self-clear bit
// [R12] start request: repeated start, bus kept
// [R13] both requests: stop, then start, clear stop
// [R14] repeated start gives 0x10; read bit switches
// [R15] arbitration loss: 0x38, release on clear
// [R16] 0x38 with start: wait free, start
// [R17] transfer suspended while flag set
// [R18] status low bits read zero
// [R19] address read bit selects receive mode
// [R20] control bit order flag down to int enable
`timescale 1ns/1ps
`include "two_wire_master_map.svh"

module two_wire_master_transmitter #(
  parameter int QUARTER = `QUARTER_CYCLES
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // two-wire bus, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  import two_wire_master_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic sda_prev_reg;
  logic busy_reg;
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      sda_prev_reg <= sda_s;
    end
  end

  // busy tracks start/stop seen on the wire, ours or another master's
  wire start_seen = scl_s & sda_prev_reg & ~sda_s;
  wire stop_seen = scl_s & ~sda_prev_reg & sda_s;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) busy_reg <= 1'b0;
    else if (start_seen) busy_reg <= 1'b1;
    else if (stop_seen) busy_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // quarter-bit enable
  // ----------------------------------------------------------------
  logic [15:0] div_reg;
  wire tick = (div_reg == 16'(QUARTER - 1));

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) div_reg <= 16'h0000;
    else if (tick) div_reg <= 16'h0000;
    else div_reg <= div_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // avalon-mm slave: one wait cycle per access
  // ----------------------------------------------------------------
  logic ack_reg;
  logic [31:0] readdata_reg;
  wire access = avs_read_i | avs_write_i;
  wire sel_ctl = (avs_address_i == `OFS_BUS_CONTROL);
  wire sel_status = (avs_address_i == `OFS_BUS_STATUS);
  wire sel_data = (avs_address_i == `OFS_SHIFT_DATA);
  wire wr_lane = avs_write_i & ack_reg & avs_byteenable_i[0];
  wire ctl_wr = wr_lane & sel_ctl;
  wire data_wr = wr_lane & sel_data;

  assign avs_waitrequest_o = access & ~ack_reg;
  assign avs_readdata_o = readdata_reg;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  bus_control_s ctl_reg;
  logic [7:0] shift_data_reg;
  logic [7:0] bus_status_reg;
  logic hw_set;
  logic stop_clr;
  logic [7:0] status_next;

  wire [7:0] ctl_rd = {ctl_reg.flag, ctl_reg.ack_enable,
                       ctl_reg.start_request, ctl_reg.stop_request,
                       ctl_reg.write_collision, ctl_reg.enable, 1'b0,
                       ctl_reg.interrupt_enable}; // [R20]
  wire flag_clr = ctl_wr & avs_writedata_i[`CTL_FLAG]; // [R2]
  wire resume = flag_clr & ctl_reg.flag;
  wire data_ok = data_wr & ctl_reg.flag;
  wire data_collide = data_wr & ~ctl_reg.flag; // [R9]
  wire wr_start = avs_writedata_i[`CTL_START];
  wire wr_stop = avs_writedata_i[`CTL_STOP];

  wire [7:0] rd_sel = sel_ctl ? ctl_rd :
                      sel_status ? bus_status_reg :
                      sel_data ? shift_data_reg : 8'h00;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_reg <= 1'b0;
      readdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= access & ~ack_reg;
      if (avs_read_i & ~ack_reg) readdata_reg <= {24'h000000, rd_sel};
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_reg <= bus_control_s'(7'h00);
    end else begin
      if (ctl_wr) begin
        ctl_reg.ack_enable <= avs_writedata_i[`CTL_ACK_ENABLE];
        ctl_reg.start_request <= wr_start;
        ctl_reg.stop_request <= wr_stop;
        ctl_reg.enable <= avs_writedata_i[`CTL_ENABLE];
        ctl_reg.interrupt_enable <= avs_writedata_i[`CTL_INT_ENABLE];
      end
      if (stop_clr) ctl_reg.stop_request <= 1'b0; // [R11] [R13]
      // hardware set wins over a simultaneous software clear
      if (hw_set) ctl_reg.flag <= 1'b1;
      else if (flag_clr) ctl_reg.flag <= 1'b0; // [R2]
      if (data_collide) ctl_reg.write_collision <= 1'b1; // [R9]
      else if (data_ok) ctl_reg.write_collision <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_data_reg <= `DATA_RESET;
      bus_status_reg <= `STATUS_RESET;
    end else begin
      if (data_ok) shift_data_reg <= avs_writedata_i[7:0]; // [R9]
      bus_status_reg <= status_next; // [R18]
    end
  end

  // ----------------------------------------------------------------
  // bus engine
  // ----------------------------------------------------------------
  engine_state_e state_reg, state_next;
  logic [1:0] phase_reg, phase_next;
  logic [3:0] bit_reg, bit_next;
  logic scl_drv_reg, scl_drv_next;
  logic sda_drv_reg, sda_drv_next;
  logic addr_reg, addr_next;
  logic read_mode_reg, read_mode_next;
  logic lost_reg, lost_next;
  logic rs_reg, rs_next;
  logic acked_reg, acked_next;

  wire last_bit = (bit_reg == 4'h8);
  wire [2:0] bit_idx = 3'h7 - bit_reg[2:0];
  wire tx_bit = last_bit | shift_data_reg[bit_idx];
  // clock stretching: the high phase waits until scl reads high
  wire stall = (phase_reg == 2'h2) & ~scl_s;
  wire step = tick & ~stall;
  wire [7:0] ack_code = addr_reg ?
    (shift_data_reg[0] ?
      (acked_reg ? `ST_ADDR_R_ACK : `ST_ADDR_R_NACK) :
      (acked_reg ? `ST_ADDR_W_ACK : `ST_ADDR_W_NACK)) :
    (acked_reg ? `ST_DATA_ACK : `ST_DATA_NACK); // [R7] [R14]

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    bit_next = bit_reg;
    scl_drv_next = scl_drv_reg;
    sda_drv_next = sda_drv_reg;
    addr_next = addr_reg;
    read_mode_next = read_mode_reg;
    lost_next = lost_reg;
    rs_next = rs_reg;
    acked_next = acked_reg;
    status_next = bus_status_reg;
    hw_set = 1'b0;
    stop_clr = 1'b0;
    case (state_reg)
      S_IDLE: begin
        scl_drv_next = 1'b0;
        sda_drv_next = 1'b0;
        lost_next = 1'b0;
        read_mode_next = 1'b0;
        rs_next = 1'b0;
        status_next = `ST_IDLE;
        if (ctl_reg.enable & ctl_reg.start_request & ~ctl_reg.flag)
          state_next = S_WAIT; // [R1] [R16]
      end
      S_WAIT: begin
        if (!ctl_reg.enable) begin
          state_next = S_IDLE;
        end else if (!busy_reg && scl_s && sda_s && tick) begin
          state_next = S_START; // [R3]
          phase_next = 2'h0;
        end
      end
      S_START: begin
        if (tick) begin
          phase_next = phase_reg + 2'h1;
          if (phase_reg == 2'h0) sda_drv_next = 1'b1;
          if (phase_reg == 2'h2) scl_drv_next = 1'b1;
          if (phase_reg == 2'h3) begin
            status_next = rs_reg ? `ST_RESTART : `ST_START; // [R4] [R14]
            hw_set = 1'b1;
            addr_next = 1'b1;
            read_mode_next = 1'b0;
            state_next = S_HOLD;
          end
        end
      end
      S_RESTART: begin
        // bus kept: sda, then scl released, then a normal start
        if (step) begin
          phase_next = phase_reg + 2'h1;
          if (phase_reg == 2'h0) sda_drv_next = 1'b0;
          if (phase_reg == 2'h1) scl_drv_next = 1'b0;
          if (phase_reg == 2'h2) begin
            rs_next = 1'b1; // [R12]
            phase_next = 2'h0;
            state_next = S_START;
          end
        end
      end
      S_BIT: begin
        // sda moves a quarter before scl rises, never with it
        if (step) begin
          phase_next = phase_reg + 2'h1;
          if (phase_reg == 2'h0) sda_drv_next = ~tx_bit;
          if (phase_reg == 2'h1) scl_drv_next = 1'b0;
          if (phase_reg == 2'h2) begin
            acked_next = ~sda_s;
            if (!last_bit && tx_bit && !sda_s) begin
              // another master pulled sda low: back off at once
              scl_drv_next = 1'b0;
              sda_drv_next = 1'b0;
              lost_next = 1'b1;
              status_next = `ST_ARB_LOST; // [R15] [R6]
              hw_set = 1'b1;
              state_next = S_HOLD;
            end
          end
          if (phase_reg == 2'h3) begin
            scl_drv_next = 1'b1;
            if (last_bit) begin
              status_next = ack_code; // [R6]
              hw_set = 1'b1;
              if (addr_reg) read_mode_next = shift_data_reg[0]; // [R19]
              addr_next = 1'b0;
              state_next = S_HOLD;
            end else begin
              bit_next = bit_reg + 4'h1;
            end
          end
        end
      end
      S_HOLD: begin
        // scl stays low while software owns the flag, except after arbitration loss, which has released it
        if (!ctl_reg.enable) begin
          state_next = S_IDLE; // [R17]
        end else if (resume) begin
          phase_next = 2'h0;
          rs_next = 1'b0;
          if (lost_reg) begin
            state_next = S_IDLE; // [R15] [R16]
          end else if (wr_stop) begin
            state_next = S_STOP; // [R11] [R13]
          end else if (wr_start) begin
            state_next = S_RESTART; // [R12]
          end else if (!read_mode_reg) begin
            bit_next = 4'h0;
            state_next = S_BIT; // [R10]
          end
        end
      end
      S_STOP: begin
        // sda low under low scl, scl up, then sda up is the stop
        if (step) begin
          phase_next = phase_reg + 2'h1;
          if (phase_reg == 2'h0) sda_drv_next = 1'b1;
          if (phase_reg == 2'h1) scl_drv_next = 1'b0;
          if (phase_reg == 2'h2) sda_drv_next = 1'b0;
          if (phase_reg == 2'h3) begin
            stop_clr = 1'b1; // [R11] [R13]
            state_next = S_IDLE;
          end
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= S_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      scl_drv_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
      addr_reg <= 1'b0;
      read_mode_reg <= 1'b0;
      lost_reg <= 1'b0;
      rs_reg <= 1'b0;
      acked_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      scl_drv_reg <= scl_drv_next;
      sda_drv_reg <= sda_drv_next;
      addr_reg <= addr_next;
      read_mode_reg <= read_mode_next;
      lost_reg <= lost_next;
      rs_reg <= rs_next;
      acked_reg <= acked_next;
    end
  end

  // ----------------------------------------------------------------
  // open-drain pins: only ever pull low
  // ----------------------------------------------------------------
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_drv_reg;
  assign sda_oe_o = sda_drv_reg;

endmodule : two_wire_master_transmitter

// >>> verif/two_wire_master_checker.sv
// port assertions for the two-wire master transmitter
`timescale 1ns/1ps
`include "two_wire_master_map.svh"
module two_wire_master_checker (
  // clock, reset, register bus
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // two-wire lines
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  logic flag_seen;
  wire logic rd_done = avs_read_i && !avs_waitrequest_o;
  wire logic ctl_rd = rd_done && avs_address_i == `OFS_BUS_CONTROL;
  wire logic ctl_clr = avs_write_i && !avs_waitrequest_o &&
    avs_address_i == `OFS_BUS_CONTROL && avs_byteenable_i[0] &&
    avs_writedata_i[7];
  // flag as last seen by software; lines must freeze meanwhile
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) flag_seen <= 1'b0;
    else if (ctl_clr) flag_seen <= 1'b0;
    else if (ctl_rd) flag_seen <= avs_readdata_o[7];
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  waitreq_first_a: assert property ($rose(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o) else $error("request not stalled");
  waitreq_once_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait too long");
  waitreq_idle_a: assert property (!(avs_read_i || avs_write_i)
    |-> !avs_waitrequest_o) else $error("wait without request");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  upper_zero_a: assert property (rd_done |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  status_low_a: assert property (rd_done &&
    avs_address_i == `OFS_BUS_STATUS |-> avs_readdata_o[2:0] == 3'h0)
    else $error("status low bits");
  reserved_zero_a: assert property (ctl_rd |-> !avs_readdata_o[1])
    else $error("reserved control bit set");
  read_hold_a: assert property (!$stable(avs_readdata_o)
    |-> $past(avs_read_i && avs_waitrequest_o)) else $error("read data moved");
  suspend_hold_a: assert property (flag_seen |-> $stable(scl_oe_o) &&
    $stable(sda_oe_o)) else $error("bus moved while suspended");
  start_free_a: assert property ($rose(sda_oe_o) && !scl_oe_o
    |-> $past(sda_i) && $past(scl_i)) else $error("start on busy bus");
endmodule : two_wire_master_checker

bind two_wire_master_transmitter two_wire_master_checker chk_u (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o));

// >>> verif/two_wire_slave_model.sv
// behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
module two_wire_slave_model #(
  parameter logic [6:0] ADDR = 7'h3a
) (
  // wired bus levels and control
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  // pull-down and observations
  output logic sda_oe_o,
  output logic [7:0] last_byte_o,
  output int stops_o
);
  int bit_n = -1;
  logic [7:0] sh = 8'h0;
  logic addr_ph = 1'b0;
  logic sel = 1'b0;
  initial begin
    sda_oe_o = 1'b0;
    last_byte_o = 8'h0;
    stops_o = 0;
  end
  always @(negedge sda_i) if (scl_i) begin
    bit_n = -1;
    addr_ph = 1'b1;
    sda_oe_o = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) begin
    stops_o++;
    sel = 1'b0;
  end
  always @(posedge scl_i) if (bit_n >= 0 && bit_n < 8) sh = {sh[6:0], sda_i};
  // ack only while selected; released right after the ninth clock
  always @(negedge scl_i) begin
    if (bit_n == 8) begin
      sda_oe_o = 1'b0;
      bit_n = 0;
    end else begin
      bit_n++;
      if (bit_n == 8) begin
        if (addr_ph) sel = sh[7:1] == ADDR && !sh[0];
        else last_byte_o = sh;
        addr_ph = 1'b0;
        sda_oe_o = sel && !nack_i;
      end
    end
  end
endmodule : two_wire_slave_model

// >>> verif/tb_top.sv
// self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
`include "two_wire_master_map.svh"
module tb_top;
  import two_wire_master_pkg::*;
  localparam logic [6:0] ADDR = 7'h3a;
  logic clock_i, rst_b_i, rd, wr, wreq, scl_oe, sda_oe, m_oe, arb_pull, nack;
  logic [3:0] adr, be;
  logic [31:0] wdata, rdata, rdv, seed;
  logic [7:0] last_byte, d;
  int stops, n0, n_fail, tests_run;
  // open-drain lines with pull-ups
  wire logic scl_w = !scl_oe;
  wire logic sda_w = !(sda_oe || m_oe || arb_pull);
  two_wire_master_transmitter #(.QUARTER(4)) dut_u (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe));
  two_wire_slave_model #(.ADDR(ADDR)) slave_u (.scl_i(scl_w),
    .sda_i(sda_w), .nack_i(nack), .sda_oe_o(m_oe),
    .last_byte_o(last_byte), .stops_o(stops));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic logic [7:0] ack_code(logic is_adr, logic ack);
    if (is_adr) return ack ? `ST_ADDR_W_ACK : `ST_ADDR_W_NACK;
    return ack ? `ST_DATA_ACK : `ST_DATA_NACK;
  endfunction : ack_code
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one avalon transfer; a gap cycle keeps requests apart
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v,
                     input logic [3:0] b);
    int n = 0;
    @(posedge clock_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdata <= {24'h0, v};
    be <= b;
    do begin
      @(posedge clock_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rdv = rdata;
    if (n >= 50) n_fail++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic wr8(input logic [3:0] a, input logic [7:0] v);
    bus(1'b1, a, v, 4'h1);
  endtask : wr8
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h0, 4'h1);
    chk(rdv, e);
  endtask : rd_chk
  task automatic wait_bit(input int b, input logic v);
    int n = 0;
    do begin
      bus(1'b0, `OFS_BUS_CONTROL, 8'h0, 4'h1);
      n++;
    end while (rdv[b] !== v && n < 2000);
    if (n >= 2000) n_fail++;
  endtask : wait_bit
  task automatic go(input logic [7:0] c, input logic [7:0] code);
    wr8(`OFS_BUS_CONTROL, c);
    wait_bit(7, 1'b1);
    rd_chk(`OFS_BUS_STATUS, {24'h0, code});
  endtask : go
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    #(40 * 30000);
    n_fail++;
    wrap_up();
  end
  initial begin
    {rst_b_i, rd, wr, arb_pull, nack} = 5'h0;
    {adr, be, wdata} = 40'h0;
    seed = 32'd91789;
    n_fail = 0;
    tests_run = 0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd_chk(`OFS_BUS_CONTROL, `CTL_RESET);
    rd_chk(`OFS_BUS_STATUS, `STATUS_RESET);
    rd_chk(`OFS_SHIFT_DATA, `DATA_RESET);
    wr8(4'hc, 8'hff);
    rd_chk(4'hc, 32'h0);
    wr8(`OFS_SHIFT_DATA, 8'h55);
    rd_chk(`OFS_BUS_CONTROL, 32'h08);
    rd_chk(`OFS_SHIFT_DATA, `DATA_RESET);
    go(8'ha4, `ST_START);
    wr8(`OFS_SHIFT_DATA, {ADDR, 1'b0});
    wr8(`OFS_BUS_CONTROL, 8'h24);
    rd_chk(`OFS_BUS_CONTROL, 32'ha4);
    rd_chk(`OFS_BUS_STATUS, `ST_START);
    go(8'h84, ack_code(1'b1, 1'b1));
    for (int i = 0; i < 3; i++) begin
      d = rnd();
      nack <= (i == 1);
      wr8(`OFS_SHIFT_DATA, d);
      bus(1'b1, `OFS_SHIFT_DATA, ~d, 4'h0);
      go(8'h84, ack_code(1'b0, i != 1));
      chk({24'h0, last_byte}, {24'h0, d});
    end
    nack <= 1'b0;
    go(8'ha4, `ST_RESTART);
    wr8(`OFS_SHIFT_DATA, {ADDR ^ 7'h01, 1'b0});
    go(8'h84, ack_code(1'b1, 1'b0));
    wr8(`OFS_SHIFT_DATA, rnd());
    go(8'h84, `ST_DATA_NACK);
    // read bit: the slave model only answers writes
    go(8'ha4, `ST_RESTART);
    wr8(`OFS_SHIFT_DATA, {ADDR, 1'b1});
    go(8'h84, `ST_ADDR_R_NACK);
    n0 = stops;
    go(8'hb4, `ST_START);
    rd_chk(`OFS_BUS_CONTROL, 32'ha4);
    chk(32'(stops), 32'(n0 + 1));
    wr8(`OFS_SHIFT_DATA, {ADDR, 1'b0});
    go(8'h84, `ST_ADDR_W_ACK);
    wr8(`OFS_BUS_CONTROL, 8'h94);
    wait_bit(4, 1'b0);
    rd_chk(`OFS_BUS_STATUS, `ST_IDLE);
    chk(32'(stops), 32'(n0 + 2));
    for (int i = 0; i < 2; i++) begin
      go(8'ha4, `ST_START);
      wr8(`OFS_SHIFT_DATA, 8'hf0);
      arb_pull <= 1'b1;
      go(8'h84, `ST_ARB_LOST);
      wr8(`OFS_BUS_CONTROL, i ? 8'ha4 : 8'h84);
      repeat (40) @(posedge clock_i);
      chk({30'h0, scl_oe, sda_oe}, 32'h0);
      if (i == 0) rd_chk(`OFS_BUS_STATUS, `ST_IDLE);
      arb_pull <= 1'b0;
      if (i == 1) begin
        wait_bit(7, 1'b1);
        rd_chk(`OFS_BUS_STATUS, `ST_START);
        wr8(`OFS_BUS_CONTROL, 8'h94);
        wait_bit(4, 1'b0);
      end
    end
    rst_b_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd_chk(`OFS_BUS_STATUS, `STATUS_RESET);
    rd_chk(`OFS_BUS_CONTROL, `CTL_RESET);
    wrap_up();
  end
endmodule : tb_top
